// [acp_dev_end.sv]
// Contract
// - Select pin high makes three pins static straps.
// - Strap chip select sets duty stabilizer.
// - Strap clock pin picks CMOS or LVDS outputs.
// - Strap data pin selects sleep.
// - Select pin low makes a serial port.
// - Chip select low to high bounds transfers.
// - Sample first sixteen rising edges, ignore more.
// - Word is read flag, address, data, MSB first.
// - Read flag zero writes data to address.
// - Read flag one shifts register out, unchanged.
// - Data out only pulls low; pull-up needed.
// - Host first issues software reset.
// - Reset bit clears registers and self-clears.
// - Power field: normal, nap, sleep; one unused.
// - Timing bit three inverts output clock.
// - Phase field delays output clock eighths.
// - Host enables stabilizer with nonzero phase.
// - Timing bit zero enables duty stabilizer.
// - Drive field selects LVDS current.
// - Termination bit enables termination, raises current.
// - Disable bit tristates all digital outputs.
// - Mode field selects output format.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module acp_dev_end (
    input  wire logic  sys_clk,
    input  wire logic  reset,
    acp_link_if.dev    link,
    output logic       duty_stabilizer_enable,
    output logic [1:0] output_mode_field,
    output logic [2:0] lvds_current_field,
    output logic       lvds_termination_enable,
    output logic       output_disable,
    output logic       out_clock_invert,
    output logic [1:0] out_clock_phase_field,
    output logic [1:0] power_down_field
);
    logic       sel_s;
    logic       cs_n_s;
    logic       sck_s;
    logic       sdi_s;
    logic       sck_prev_q;
    logic       cs_n_prev_q;
    logic [4:0] cnt_q;
    logic [15:0] shift_q;
    logic [7:0] power_q;
    logic [7:0] timing_q;
    logic [7:0] drive_q;
    logic       rd_q;
    logic [7:0] rd_sh_q;
    logic       sdo_oe_q;
    logic       sdo_out_q;
    logic       serial_mode;
    logic       active;
    logic       sck_rise;
    logic       sck_fall;
    logic       frame_end;
    logic       commit;
    logic       soft_rst;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;

    // Pins come from another domain, so all of them pass two flops first.
    acp_sync #(
        .W       (4),
        .RST_VAL (4'h4)
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .reset   (reset),
        .d       ({link.interface_select_pin, link.cs_n, link.sck, link.sdi}),
        .q       ({sel_s, cs_n_s, sck_s, sdi_s})
    );

    // Previous samples for edge detection on the synchronised pins.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sck_prev_q  <= 1'h0;
            cs_n_prev_q <= 1'h1;
        end
        else
        begin
            sck_prev_q  <= sck_s;
            cs_n_prev_q <= cs_n_s;
        end
    end

    // The port only exists while the select pin is low.
    assign serial_mode = ~sel_s;
    assign active      = serial_mode & ~cs_n_s;
    assign sck_rise    = active & sck_s & ~sck_prev_q;
    assign sck_fall    = active & ~sck_s & sck_prev_q;
    assign frame_end   = serial_mode & cs_n_s & ~cs_n_prev_q;
    assign wr_addr     = shift_q[acp_pkg::ADDR_MSB:acp_pkg::ADDR_LSB];
    assign wr_data     = shift_q[acp_pkg::DATA_MSB:0];

    // Bit counter restarts with every frame and stops at sixteen.
    always_ff @(posedge sys_clk)
    begin
        if (reset || !active)
        begin
            cnt_q <= 5'h00;
        end
        else if (sck_rise && cnt_q != acp_pkg::WORD_CNT)
        begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // Incoming bits enter at the bottom, so the first bit ends up on top.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            shift_q <= 16'h0000;
        end
        else if (sck_rise && cnt_q != acp_pkg::WORD_CNT)
        begin
            shift_q <= {shift_q[14:0], sdi_s};
        end
    end

    // A write takes effect only when a full word was seen before chip
    // select rose; a short frame leaves every register alone.
    assign commit   = frame_end && cnt_q == acp_pkg::WORD_CNT
                      && !shift_q[acp_pkg::READ_FLAG_BIT];
    assign soft_rst = commit && wr_addr == acp_pkg::ADDR_RESET
                      && wr_data[acp_pkg::RESET_BIT];

    // Mode registers; only the defined bits are kept.
    always_ff @(posedge sys_clk)
    begin
        if (reset || soft_rst)
        begin
            power_q  <= acp_pkg::REG_RESET_VAL;
            timing_q <= acp_pkg::REG_RESET_VAL;
            drive_q  <= acp_pkg::REG_RESET_VAL;
        end
        else if (commit)
        begin
            case (wr_addr)
                acp_pkg::ADDR_POWER:  power_q  <= wr_data & acp_pkg::MASK_POWER;
                acp_pkg::ADDR_TIMING: timing_q <= wr_data & acp_pkg::MASK_TIMING;
                acp_pkg::ADDR_DRIVE:  drive_q  <= wr_data & acp_pkg::MASK_DRIVE;
                default:              power_q  <= power_q;
            endcase
        end
    end

    // Readback value; the reset bit always reads zero since it self-clears.
    function automatic logic [7:0] reg_value(input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            acp_pkg::ADDR_POWER:  v = power_q;
            acp_pkg::ADDR_TIMING: v = timing_q;
            acp_pkg::ADDR_DRIVE:  v = drive_q;
            default:              v = 8'h00;
        endcase
        return v;
    endfunction

    // After the eighth bit the header is known; the first data bit is put
    // out on that falling edge so the host can take it at the ninth rise.
    always_ff @(posedge sys_clk)
    begin
        if (reset || !active)
        begin
            rd_q    <= 1'h0;
            rd_sh_q <= 8'hff;
        end
        else if (sck_fall && cnt_q == acp_pkg::HDR_CNT)
        begin
            rd_q    <= shift_q[acp_pkg::DATA_MSB];
            rd_sh_q <= reg_value(shift_q[6:0]);
        end
        else if (sck_fall && rd_q)
        begin
            rd_sh_q <= {rd_sh_q[6:0], 1'h1};
        end
    end

    // The pin is only ever pulled low; a one is left to the pull-up.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sdo_oe_q  <= 1'h0;
            sdo_out_q <= 1'h0;
        end
        else
        begin
            sdo_oe_q  <= active & rd_q & ~rd_sh_q[7];
            sdo_out_q <= 1'h0;
        end
    end

    assign link.sdo_oe  = sdo_oe_q;
    assign link.sdo_out = sdo_out_q;

    // Effective configuration. Unused codes fall back to a safe neighbour:
    // power code 10 runs normally, mode 11 gives full-rate CMOS and
    // current 011 gives the default current.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            duty_stabilizer_enable  <= 1'h0;
            output_mode_field       <= acp_pkg::MODE_CMOS;
            lvds_current_field      <= acp_pkg::CUR_3P5;
            lvds_termination_enable <= 1'h0;
            output_disable          <= 1'h0;
            out_clock_invert        <= 1'h0;
            out_clock_phase_field   <= acp_pkg::PHASE_NONE;
            power_down_field        <= acp_pkg::PD_NORMAL;
        end
        else if (sel_s)
        begin
            duty_stabilizer_enable  <= cs_n_s;
            output_mode_field       <= sck_s ? acp_pkg::MODE_LVDS
                                             : acp_pkg::MODE_CMOS;
            lvds_current_field      <= acp_pkg::CUR_3P5;
            lvds_termination_enable <= 1'h0;
            output_disable          <= 1'h0;
            out_clock_invert        <= 1'h0;
            out_clock_phase_field   <= acp_pkg::PHASE_NONE;
            power_down_field        <= sdi_s ? acp_pkg::PD_SLEEP
                                             : acp_pkg::PD_NORMAL;
        end
        else
        begin
            duty_stabilizer_enable  <= timing_q[acp_pkg::DCS_BIT];
            out_clock_invert        <= timing_q[acp_pkg::INV_BIT];
            out_clock_phase_field   <= timing_q[acp_pkg::PHASE_LSB +: 2];
            lvds_termination_enable <= drive_q[acp_pkg::TERM_BIT];
            output_disable          <= drive_q[acp_pkg::OFF_BIT];
            if (drive_q[acp_pkg::CUR_LSB +: 3] == acp_pkg::CUR_UNUSED)
            begin
                lvds_current_field <= acp_pkg::CUR_3P5;
            end
            else
            begin
                lvds_current_field <= drive_q[acp_pkg::CUR_LSB +: 3];
            end
            if (drive_q[acp_pkg::MODE_LSB +: 2] == acp_pkg::MODE_UNUSED)
            begin
                output_mode_field <= acp_pkg::MODE_CMOS;
            end
            else
            begin
                output_mode_field <= drive_q[acp_pkg::MODE_LSB +: 2];
            end
            if (power_q[acp_pkg::PD_LSB +: 2] == acp_pkg::PD_UNUSED)
            begin
                power_down_field <= acp_pkg::PD_NORMAL;
            end
            else
            begin
                power_down_field <= power_q[acp_pkg::PD_LSB +: 2];
            end
        end
    end
endmodule
`default_nettype wire

// [acp_pkg.sv]
package acp_pkg;

    // Serial word layout: read flag, seven address bits, eight data bits.
    localparam int        WORD_BITS     = 16;
    localparam logic [4:0] WORD_CNT     = 5'h10;
    localparam logic [4:0] HDR_CNT      = 5'h08;
    localparam int        READ_FLAG_BIT = 15;
    localparam int        ADDR_MSB      = 14;
    localparam int        ADDR_LSB      = 8;
    localparam int        DATA_MSB      = 7;

    // Mode control register addresses.
    localparam logic [6:0] ADDR_RESET  = 7'h00;
    localparam logic [6:0] ADDR_POWER  = 7'h01;
    localparam logic [6:0] ADDR_TIMING = 7'h02;
    localparam logic [6:0] ADDR_DRIVE  = 7'h03;

    // Reset values and the bits that each register really holds.
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [7:0] MASK_POWER    = 8'h03;
    localparam logic [7:0] MASK_TIMING   = 8'h0f;
    localparam logic [7:0] MASK_DRIVE    = 8'h7f;

    // Field positions.
    localparam int RESET_BIT = 7;
    localparam int PD_LSB    = 0;
    localparam int DCS_BIT   = 0;
    localparam int PHASE_LSB = 1;
    localparam int INV_BIT   = 3;
    localparam int MODE_LSB  = 0;
    localparam int OFF_BIT   = 2;
    localparam int TERM_BIT  = 3;
    localparam int CUR_LSB   = 4;

    // Field codes.
    localparam logic [1:0] PD_NORMAL   = 2'h0;
    localparam logic [1:0] PD_UNUSED   = 2'h2;
    localparam logic [1:0] PHASE_NONE  = 2'h0;
    localparam logic [1:0] MODE_CMOS   = 2'h0;
    localparam logic [1:0] MODE_LVDS   = 2'h1;
    localparam logic [1:0] MODE_UNUSED = 2'h3;
    localparam logic [1:0] PD_SLEEP    = 2'h3;
    localparam logic [2:0] CUR_3P5     = 3'h0;
    localparam logic [2:0] CUR_UNUSED  = 3'h3;

    // Serial clock made by the host: half period in ns and in system clocks.
    localparam int         SYS_CLK_NS   = 5;
    localparam int         SCK_HALF_NS  = 80;
    localparam logic [5:0] SCK_HALF_CYC = 6'((SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

    // Host command port map and bits.
    localparam logic [1:0] HADDR_MODE   = 2'h0;
    localparam logic [1:0] HADDR_CMD    = 2'h1;
    localparam logic [1:0] HADDR_STATUS = 2'h2;
    localparam logic [1:0] HADDR_RDATA  = 2'h3;
    localparam int         MODE_SEL_BIT = 0;
    localparam int         MODE_CS_BIT  = 1;
    localparam int         MODE_SCK_BIT = 2;
    localparam int         MODE_SDI_BIT = 3;
    localparam int         STAT_BUSY    = 0;
    localparam int         STAT_NEEDRST = 1;

    typedef enum logic [4:0] {
        ACP_IDLE  = 5'h01,
        ACP_SETUP = 5'h02,
        ACP_HIGH  = 5'h04,
        ACP_LOW   = 5'h08,
        ACP_TAIL  = 5'h10
    } acp_host_state_t;

endpackage

// [acp_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface acp_link_if;
    logic interface_select_pin;
    logic cs_n;
    logic sck;
    logic sdi;
    logic sdo_out;
    logic sdo_oe;
    wire  sdo;

    // Open-drain line with the external pull-up modelled as a high default.
    assign sdo = sdo_oe ? sdo_out : 1'h1;

    modport dev  (input interface_select_pin, cs_n, sck, sdi, output sdo_out, sdo_oe);
    modport host (output interface_select_pin, cs_n, sck, sdi, input sdo);
endinterface
`default_nettype wire

// [acp_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module acp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // Two stages; only the second stage is read by any logic.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [acp_host_end.sv]
`timescale 1ns/1ps
`default_nettype none
module acp_host_end (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    acp_link_if.host         link,
    input  wire logic [1:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata
);
    acp_pkg::acp_host_state_t state_q;
    logic [3:0]  mode_q;
    logic        need_rst_q;
    logic [15:0] word_q;
    logic [7:0]  rx_q;
    logic [4:0]  bit_q;
    logic [5:0]  tmr_q;
    logic        cs_n_q;
    logic        sck_q;
    logic        sdi_q;
    logic        sdo_s;
    logic        idle;
    logic        tmr_done;
    logic        is_reset_word;
    logic        cmd_ok;
    logic [15:0] cmd_word;

    acp_sync #(
        .W       (1),
        .RST_VAL (1'h1)
    ) u_sdo_sync (
        .sys_clk (sys_clk),
        .reset   (reset),
        .d       (link.sdo),
        .q       (sdo_s)
    );

    assign idle          = state_q == acp_pkg::ACP_IDLE;
    assign tmr_done      = tmr_q == acp_pkg::SCK_HALF_CYC - 6'h01;
    assign is_reset_word = !reg_wdata[acp_pkg::READ_FLAG_BIT]
                           && reg_wdata[acp_pkg::ADDR_MSB:acp_pkg::ADDR_LSB] == acp_pkg::ADDR_RESET
                           && reg_wdata[acp_pkg::RESET_BIT];
    // Until a software reset has gone out, other commands are refused.
    assign cmd_ok = reg_write && reg_addr == acp_pkg::HADDR_CMD && idle
                    && !mode_q[acp_pkg::MODE_SEL_BIT]
                    && (!need_rst_q || is_reset_word);

    // A nonzero phase may only be sent with the stabilizer bit set.
    always_comb
    begin
        cmd_word = reg_wdata;
        if (!reg_wdata[acp_pkg::READ_FLAG_BIT]
            && reg_wdata[acp_pkg::ADDR_MSB:acp_pkg::ADDR_LSB] == acp_pkg::ADDR_TIMING
            && reg_wdata[acp_pkg::PHASE_LSB +: 2] != acp_pkg::PHASE_NONE)
        begin
            cmd_word[acp_pkg::DCS_BIT] = 1'h1;
        end
    end

    // Mode register changes only between frames so the strap never moves
    // under a transfer.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            mode_q <= 4'h0;
        end
        else if (reg_write && reg_addr == acp_pkg::HADDR_MODE && idle)
        begin
            mode_q <= reg_wdata[3:0];
        end
    end

    // Tracks whether the first serial command, a software reset, was sent.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            need_rst_q <= 1'h1;
        end
        else if (cmd_ok && is_reset_word)
        begin
            need_rst_q <= 1'h0;
        end
    end

    // Frame engine: chip select low, sixteen clock pulses, chip select high.
    // Data changes on the falling edge and is read back at the rising edge.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_q <= acp_pkg::ACP_IDLE;
            cs_n_q  <= 1'h1;
            sck_q   <= 1'h0;
            sdi_q   <= 1'h0;
            tmr_q   <= 6'h00;
            bit_q   <= 5'h00;
            word_q  <= 16'h0000;
            rx_q    <= 8'h00;
        end
        else
        begin
            case (state_q)
                acp_pkg::ACP_IDLE:
                begin
                    tmr_q <= 6'h00;
                    bit_q <= 5'h00;
                    if (mode_q[acp_pkg::MODE_SEL_BIT])
                    begin
                        cs_n_q <= mode_q[acp_pkg::MODE_CS_BIT];
                        sck_q  <= mode_q[acp_pkg::MODE_SCK_BIT];
                        sdi_q  <= mode_q[acp_pkg::MODE_SDI_BIT];
                    end
                    else if (cmd_ok)
                    begin
                        word_q  <= cmd_word;
                        cs_n_q  <= 1'h0;
                        sck_q   <= 1'h0;
                        sdi_q   <= cmd_word[acp_pkg::READ_FLAG_BIT];
                        state_q <= acp_pkg::ACP_SETUP;
                    end
                    else
                    begin
                        cs_n_q <= 1'h1;
                        sck_q  <= 1'h0;
                    end
                end
                acp_pkg::ACP_SETUP, acp_pkg::ACP_LOW:
                begin
                    tmr_q <= tmr_done ? 6'h00 : tmr_q + 6'h01;
                    if (tmr_done)
                    begin
                        sck_q   <= 1'h1;
                        state_q <= acp_pkg::ACP_HIGH;
                        if (bit_q >= acp_pkg::HDR_CNT)
                        begin
                            rx_q <= {rx_q[6:0], sdo_s};
                        end
                    end
                end
                acp_pkg::ACP_HIGH:
                begin
                    tmr_q <= tmr_done ? 6'h00 : tmr_q + 6'h01;
                    if (tmr_done)
                    begin
                        sck_q  <= 1'h0;
                        bit_q  <= bit_q + 5'h01;
                        word_q <= {word_q[14:0], 1'h0};
                        sdi_q  <= word_q[14];
                        if (bit_q == acp_pkg::WORD_CNT - 5'h01)
                        begin
                            state_q <= acp_pkg::ACP_TAIL;
                        end
                        else
                        begin
                            state_q <= acp_pkg::ACP_LOW;
                        end
                    end
                end
                acp_pkg::ACP_TAIL:
                begin
                    tmr_q <= tmr_done ? 6'h00 : tmr_q + 6'h01;
                    if (tmr_done)
                    begin
                        cs_n_q  <= 1'h1;
                        state_q <= acp_pkg::ACP_IDLE;
                    end
                end
                default:
                begin
                    state_q <= acp_pkg::ACP_IDLE;
                    cs_n_q  <= 1'h1;
                end
            endcase
        end
    end

    assign link.interface_select_pin = mode_q[acp_pkg::MODE_SEL_BIT];
    assign link.cs_n = cs_n_q;
    assign link.sck  = sck_q;
    assign link.sdi  = sdi_q;

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge sys_clk)
    begin
        if (reset || !reg_read)
        begin
            reg_rdata <= 16'h0000;
        end
        else
        begin
            case (reg_addr)
                acp_pkg::HADDR_MODE:   reg_rdata <= {12'h000, mode_q};
                acp_pkg::HADDR_CMD:    reg_rdata <= word_q;
                acp_pkg::HADDR_STATUS: reg_rdata <= {14'h0, need_rst_q, !idle};
                acp_pkg::HADDR_RDATA:  reg_rdata <= {8'h00, rx_q};
                default:               reg_rdata <= 16'h0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// [acp_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module acp_assertions (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic interface_select_pin,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic       sck_q;
    logic       rd_q;
    logic [7:0] rise_q;
    // Count link clock rises in a frame; the first rise latches the read flag.
    always_ff @(posedge sys_clk)
    begin
        sck_q <= sck;
        rise_q <= (reset || cs_n) ? 8'h00 : rise_q + 8'(sck && !sck_q);
        if (sck && !sck_q && rise_q == 8'h00) rd_q <= sdi;
    end
    property p_pull_low; sdo_oe |-> !sdo_out; endproperty
    a_pull_low: assert property (p_pull_low) else $error("data out driven high");
    property p_strap_quiet; interface_select_pin [*8] |-> !sdo_oe; endproperty
    a_strap_quiet: assert property (p_strap_quiet) else $error("drive in strap mode");
    property p_idle_quiet; cs_n [*8] |-> !sdo_oe; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("drive outside frame");
    property p_read_only; sdo_oe && !cs_n |-> rise_q >= 8'h08 && rd_q; endproperty
    a_read_only: assert property (p_read_only) else $error("drive out of place");
    property p_sixteen;
        $rose(cs_n) && !interface_select_pin && !$past(interface_select_pin) |-> rise_q == 8'h10;
    endproperty
    a_sixteen: assert property (p_sixteen) else $error("frame length wrong");
    property p_half; $rose(sck) && !cs_n && !interface_select_pin |-> sck [*8] ##9 !sck; endproperty
    a_half: assert property (p_half) else $error("clock high time wrong");
    property p_sdi; !cs_n && sck && !interface_select_pin |-> $stable(sdi); endproperty
    a_sdi: assert property (p_sdi) else $error("data moved while clock high");
    property p_idle_sck; cs_n && !interface_select_pin && !$past(interface_select_pin) |-> !sck;
    endproperty
    a_idle_sck: assert property (p_idle_sck) else $error("clock high while idle");
    c_read: cover property (sdo_oe && !cs_n);
    c_frame: cover property ($rose(cs_n) && !interface_select_pin);
    c_strap: cover property (interface_select_pin && !cs_n && sck);
endmodule
`default_nettype wire

// [adc_mode_config_port_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_mode_config_port_bench;
    logic        sys_clk = 1'h0;
    logic        reset = 1'h1;
    logic [1:0]  ra = 2'h0;
    logic [15:0] wd = 16'h0000;
    logic        we = 1'h0;
    logic        re = 1'h0;
    logic [15:0] rdata;
    logic [15:0] got;
    wire logic [12:0] o;
    logic [7:0]  sh [4] = '{default: 8'h00};
    logic [7:0]  msk [4] = '{8'h00, acp_pkg::MASK_POWER, acp_pkg::MASK_TIMING, acp_pkg::MASK_DRIVE};
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          seed = 83677;
    acp_link_if link ();
    acp_dev_end acp_dev_end_i (.sys_clk(sys_clk), .reset(reset), .link(link.dev),
        .duty_stabilizer_enable(o[0]), .out_clock_phase_field(o[2:1]), .out_clock_invert(o[3]),
        .output_mode_field(o[5:4]), .output_disable(o[6]), .lvds_termination_enable(o[7]),
        .lvds_current_field(o[10:8]), .power_down_field(o[12:11]));
    acp_host_end acp_host_end_i (.sys_clk(sys_clk), .reset(reset), .link(link.host),
        .reg_addr(ra), .reg_wdata(wd), .reg_write(we), .reg_read(re), .reg_rdata(rdata));
    acp_assertions acp_assertions_i (.sys_clk(sys_clk), .reset(reset),
        .interface_select_pin(link.interface_select_pin), .cs_n(link.cs_n), .sck(link.sck),
        .sdi(link.sdi), .sdo_out(link.sdo_out), .sdo_oe(link.sdo_oe));
    // Free-running system clock.
    always #2.5 sys_clk = ~sys_clk;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        ra <= a;
        wd <= d;
        we <= 1'h1;
        @(posedge sys_clk);
        we <= 1'h0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd(input logic [1:0] a);
        @(posedge sys_clk);
        ra <= a;
        re <= 1'h1;
        @(posedge sys_clk);
        re <= 1'h0;
        #1 got = rdata;
    endtask
    // Send one word, then poll busy with a bound; the device commits a few cycles later.
    task automatic cmd(input logic [15:0] w);
        int i;
        wr(acp_pkg::HADDR_CMD, w);
        for (i = 0; i < 400; i++)
        begin
            rd(acp_pkg::HADDR_STATUS);
            if (got[acp_pkg::STAT_BUSY] === 1'h0) break;
        end
        if (i == 400)
        begin
            n_mismatch++;
            print_verdict();
        end
        repeat (8) @(posedge sys_clk);
    endtask
    // Unused codes act as the default code, while readback keeps what was written.
    function automatic logic [12:0] eff();
        logic [7:0] p;
        logic [7:0] d;
        p = sh[1];
        d = sh[3];
        if (p[1:0] == 2'h2) p = 8'h00;
        if (d[6:4] == 3'h3) d[6:4] = 3'h0;
        if (d[1:0] == 2'h3) d[1:0] = 2'h0;
        return {p[1:0], d[6:0], sh[2][3:0]};
    endfunction
    task automatic put(input logic [6:0] a, input logic [7:0] v);
        if (a == 7'h02 && v[2:1] != 2'h0) v[0] = 1'h1;
        cmd({1'h0, a, v});
        if (a == 7'h00 && v[7]) sh = '{default: 8'h00};
        else if (a < 7'h04) sh[a[1:0]] = v & msk[a[1:0]];
        cmd({1'h1, a, 8'h00});
        rd(acp_pkg::HADDR_RDATA);
        chk({8'h00, got[7:0]}, {8'h00, (a < 7'h04) ? sh[a[1:0]] : 8'h00});
        chk(16'(o), 16'(eff()));
    endtask
    initial
    begin
        int i;
        int k;
        repeat (12) @(posedge sys_clk);
        reset <= 1'h0;
        cmd({1'h0, acp_pkg::ADDR_POWER, 8'h03});
        rd(acp_pkg::HADDR_STATUS);
        chk({14'h0, got[1:0]}, 16'h0002);
        chk(16'(o), 16'h0000);
        put(7'h00, 8'h80);
        rd(acp_pkg::HADDR_STATUS);
        chk(got, 16'h0000);
        put(7'h01, 8'h02);
        put(7'h03, 8'hbb);
        put(7'h45, 8'hff);
        put(7'h02, 8'h0c);
        $display("test corners done");
        for (i = 0; i < 12; i++)
        begin
            k = $random(seed);
            put(7'h01 + 7'(k[9:8] % 2'h3), k[7:0]);
        end
        $display("test random done");
        put(7'h00, 8'h80);
        $display("test reset done");
        for (i = 0; i < 8; i++)
        begin
            wr(acp_pkg::HADDR_MODE, 16'(i * 2 + 1));
            repeat (8) @(posedge sys_clk);
            chk(16'(o), 16'({i[2] ? 2'h3 : 2'h0, 6'h00, i[1], 3'h0, i[0]}));
            rd(acp_pkg::HADDR_MODE);
            chk(got, 16'(i * 2 + 1));
        end
        wr(acp_pkg::HADDR_MODE, 16'h0000);
        $display("test strap done");
        print_verdict();
    end
endmodule
`default_nettype wire
